// *** ccp_pkg.sv ***
// Constants, types and register map of the canceler control-pin block
// What this block does
// [RULE1] Line attenuator enable pin active low, ORed with register 4 bit 1.
// [RULE2] Receive-only input selects send attenuator; send or both select receive.
// [RULE3] Each active line howling attenuator cuts about 6 dB.
// [RULE4] Line attenuator works only while line canceler is in normal mode.
// [RULE5] Dynamic pins sampled on frame sync rise; driver holds them 250 us.
// [RULE6] Acoustic level pin: low 6 dB, high 12 dB, ORed with register 5 bit 1.
// [RULE7] Acoustic receive-only selects send attenuator; send or both select receive one.
// [RULE8] Gain controller acts only at receive level -10 dBm0 or above.
// [RULE9] Gain-control pins active low, normal mode only, ORed with 4.0 and 5.0.
// [RULE10] Pad mode pin: low through, high pad; ORed with register 1 bit 2.
// [RULE11] Pad levels from register 10: 0, 6, 12, 18 dB; default 12 dB.
// [RULE12] Host should set output pad positive and equal to input pad.
// [RULE13] Host issues a coefficient reset after changing the pad mode.
// [RULE14] Coefficient reset clears filters, keeps registers, silences output.
// [RULE15] Noise code 00 17 dB, 11 13.5 dB, 10 8 dB, 01 through.
// [RULE16] Noise level latched at initial-mode release; new level needs powerdown.
// [RULE17] Noise select low ORed with register 1 bit 0, high with 12 bit 2.
// [RULE18] Noise pad code gives output gain and input cut of 0 to 18 dB.
// [RULE19] Thirteen control bytes reachable through a four-wire serial port.
// [RULE20] Unused serial port: enable high, clock and data low, select high.
// [RULE21] Port-select pin low marks serial port used; ORed with 0 bit 1.
// [RULE22] Four receive gain pins ORed with register 2 bits 3 to 0.
// [RULE23] Serial frame: read flag, four address bits, eight data bits, MSB first.
package ccp_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int NUM_CR = 13;
  localparam logic [7:0] CR_LAST_OFF = 8'h30;
  localparam logic [7:0] STATUS_OFF = 8'h34;
  localparam logic [7:0] CR_RST = 8'h00;
  localparam logic [7:0] CR10_RST = 8'h26;
  localparam int IDX_CR0 = 0;
  localparam int IDX_CR1 = 1;
  localparam int IDX_CR2 = 2;
  localparam int IDX_CR4 = 4;
  localparam int IDX_CR5 = 5;
  localparam int IDX_CR10 = 10;
  localparam int IDX_CR12 = 12;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CR0_MCU_B = 1;
  localparam int CR0_COEF_B = 6;
  localparam int CR0_PDN_B = 7;
  localparam int CR1_NCLO_B = 0;
  localparam int CR1_PAD_B = 2;
  localparam int CRX_GC_B = 0;
  localparam int CRX_ATT_B = 1;
  localparam int CRX_NCPAD_B = 2;
  localparam int CRX_THR_B = 7;
  localparam int CR12_NCHI_B = 2;
  localparam int CR10_IN_MAG_B = 0;
  localparam int CR10_IN_NEG_B = 2;
  localparam int CR10_OUT_MAG_B = 4;
  localparam int CR10_OUT_NEG_B = 6;

  // ---------------------------------------------------------------
  // Levels and codes
  // ---------------------------------------------------------------
  localparam logic [4:0] LINE_ATT_DB = 5'h06;
  localparam logic [4:0] ACO_ATT_LO_DB = 5'h06;
  localparam logic [4:0] ACO_ATT_HI_DB = 5'h0C;
  localparam logic [5:0] PAD_STEP_DB = 6'h06;
  localparam logic [5:0] NC_ATT_17 = 6'h22;
  localparam logic [5:0] NC_ATT_13P5 = 6'h1B;
  localparam logic [5:0] NC_ATT_8 = 6'h10;
  localparam logic [1:0] NC_THROUGH = 2'h1;
  localparam logic [3:0] SER_HDR_BITS = 4'h5;
  localparam logic [3:0] SER_FRAME_BITS = 4'hD;
  localparam int INIT_CYCLES_DEF = 16;
  localparam int COEF_CLR_CYCLES_DEF = 16;

  typedef enum logic [1:0] {
    CCP_PDN = 2'b00,
    CCP_INIT = 2'b01,
    CCP_RUN = 2'b11
  } ccp_mode_e;

  // Pins from the host, after synchronisation
  typedef struct packed {
    logic line_howl_atten_en_n;
    logic acoustic_atten_level_sel;
    logic line_rx_gain_ctrl_dis;
    logic acoustic_rx_gain_ctrl_dis;
    logic pad_stage_mode;
    logic coef_reset_n;
    logic noise_sel_lo;
    logic noise_sel_hi;
    logic noise_pad_lo;
    logic noise_pad_hi;
    logic ser_port_unused;
    logic powerdown_reset_n;
    logic line_ec_through;
    logic acoustic_ec_through;
    logic [3:0] rx_gain;
  } ccp_pins_s;

  localparam ccp_pins_s PINS_RST = 18'h210C0;

  // Controls handed to the signal path
  typedef struct packed {
    logic line_send_atten;
    logic line_recv_atten;
    logic [4:0] line_atten_db;
    logic acoustic_send_atten;
    logic acoustic_recv_atten;
    logic [4:0] acoustic_atten_db;
    logic line_gain_ctrl_act;
    logic acoustic_gain_ctrl_act;
    logic pad_active;
    logic [5:0] input_atten_pad;
    logic [5:0] output_gain_pad;
    logic coef_reset;
    logic silence;
    logic noise_through;
    logic [5:0] noise_atten_x2;
    logic [5:0] noise_out_gain;
    logic [5:0] noise_in_atten;
    logic ser_port_used;
    logic [3:0] rx_gain_code;
    logic init_mode;
  } ccp_ctrl_s;

  // Signed pad level in dB from a magnitude code and a sign
  function automatic logic [5:0] pad_db(input logic [1:0] mag,
                                        input logic neg);
    logic [5:0] v;
    v = 6'(6'(mag) * PAD_STEP_DB);
    return neg ? 6'(-v) : v;
  endfunction

endpackage

// *** ccp_sync.sv ***
// Two-flop synchroniser bank for host pins
`timescale 1ns/100ps
module ccp_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] rst_val_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage only feeds the second
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i ^ rst_val_i;
      sync_q <= meta_q;
    end
  end

  // Idle levels restored so reset shows inactive pins
  assign sync_o = sync_q ^ rst_val_i;

endmodule

// *** ccp_top.sv ***
// Canceler control-pin logic with register bank and serial port
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module ccp_top #(
  parameter int INIT_CYCLES = ccp_pkg::INIT_CYCLES_DEF,
  parameter int COEF_CLR_CYCLES = ccp_pkg::COEF_CLR_CYCLES_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire ccp_pkg::ccp_pins_s pins_i,
  input wire logic frame_sync_i,
  input wire logic ser_enable_n_i,
  input wire logic ser_shift_clk_i,
  input wire logic ser_data_in_i,
  output logic ser_data_out_o,
  input wire logic line_recv_input_i,
  input wire logic line_send_input_i,
  input wire logic acoustic_recv_input_i,
  input wire logic acoustic_send_input_i,
  input wire logic line_rx_level_high_i,
  input wire logic acoustic_rx_level_high_i,
  output ccp_pkg::ccp_ctrl_s ctrl_o
);

  localparam int PW = $bits(ccp_pkg::ccp_pins_s);
  localparam int SW = PW + 4;

  if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_chk_init
    $error("INIT_CYCLES out of range");
  end
  if (COEF_CLR_CYCLES < 1 || COEF_CLR_CYCLES > 65535) begin : g_chk_coef
    $error("COEF_CLR_CYCLES out of range");
  end

  // ---------------------------------------------------------------
  // Pin synchronisation and frame-sync edge
  // ---------------------------------------------------------------
  logic [SW-1:0] sync_v;
  ccp_pkg::ccp_pins_s pins_s;
  logic fs_s, s_en_n, s_clk, s_din;
  logic fs_dly_q, sclk_dly_q, fs_rise, s_rise;
  ccp_pkg::ccp_pins_s samp_q, samp_d;

  ccp_sync #(.W(SW)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .rst_val_i({ccp_pkg::PINS_RST, 4'h4}),
    .async_i({pins_i, frame_sync_i, ser_enable_n_i, ser_shift_clk_i,
              ser_data_in_i}),
    .sync_o(sync_v)
  );

  assign pins_s = sync_v[SW-1:4];
  assign fs_s = sync_v[3];
  assign s_en_n = sync_v[2];
  assign s_clk = sync_v[1];
  assign s_din = sync_v[0];
  assign fs_rise = fs_s & ~fs_dly_q;
  assign s_rise = s_clk & ~sclk_dly_q;

  // Dynamic pins captured once per frame
  always_comb begin
    samp_d = samp_q;
    if (fs_rise) begin
      samp_d = pins_s; // RULE5
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      samp_q <= ccp_pkg::PINS_RST;
      fs_dly_q <= 1'b0;
      sclk_dly_q <= 1'b0;
    end else begin
      samp_q <= samp_d;
      fs_dly_q <= fs_s;
      sclk_dly_q <= s_clk;
    end
  end

  // ---------------------------------------------------------------
  // Register bank, APB slave and serial port
  // ---------------------------------------------------------------
  logic [7:0] cr_q [ccp_pkg::NUM_CR];
  logic [7:0] cr_d [ccp_pkg::NUM_CR];
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d, status_w;
  logic apb_acc, apb_cr_hit, apb_st_hit, apb_wr;
  logic [3:0] apb_idx;
  logic [3:0] ser_cnt_q, ser_cnt_d;
  logic [12:0] ser_sh_q, ser_sh_d;
  logic [7:0] ser_out_q, ser_out_d;
  logic ser_wr, ser_used;
  ccp_pkg::ccp_mode_e mode_q, mode_d;
  logic [5:0] nc_att_q, nc_att_d;
  ccp_pkg::ccp_ctrl_s ctrl_q, ctrl_d;

  assign apb_acc = psel_i & penable_i & ~pready_q;
  assign apb_idx = paddr_i[5:2];
  assign apb_cr_hit = (paddr_i[1:0] == 2'h0) &&
                      (paddr_i <= ccp_pkg::CR_LAST_OFF);
  assign apb_st_hit = (paddr_i == ccp_pkg::STATUS_OFF);
  assign apb_wr = apb_acc & pwrite_i & apb_cr_hit;
  assign status_w = {23'h000000, ctrl_q.coef_reset, nc_att_q, mode_q};
  assign ser_used = ~(pins_s.ser_port_unused |
                      cr_q[ccp_pkg::IDX_CR0][ccp_pkg::CR0_MCU_B]); // RULE21

  // Answer one cycle into the access phase
  always_comb begin
    pready_d = apb_acc;
    pslverr_d = apb_acc & ~apb_cr_hit & ~(apb_st_hit & ~pwrite_i);
    prdata_d = 32'h00000000;
    if (apb_acc && !pwrite_i && apb_cr_hit) begin
      prdata_d = {24'h000000, cr_q[apb_idx]};
    end else if (apb_acc && !pwrite_i && apb_st_hit) begin
      prdata_d = status_w;
    end
  end

  // Serial frame: read flag, address, data, shifted on clock rise
  always_comb begin
    ser_cnt_d = ser_cnt_q;
    ser_sh_d = ser_sh_q;
    ser_out_d = ser_out_q;
    ser_wr = 1'b0;
    if (s_en_n || !ser_used) begin
      ser_cnt_d = 4'h0; // RULE19
    end else if (s_rise && ser_cnt_q < ccp_pkg::SER_FRAME_BITS) begin
      ser_sh_d = {ser_sh_q[11:0], s_din}; // RULE23
      ser_cnt_d = ser_cnt_q + 4'h1;
      ser_out_d = {ser_out_q[6:0], 1'b0};
      if (ser_cnt_q == ccp_pkg::SER_HDR_BITS - 4'h1) begin
        ser_out_d = 8'h00;
        if (ser_sh_d[4] && ser_sh_d[3:0] < 4'(ccp_pkg::NUM_CR)) begin
          ser_out_d = cr_q[ser_sh_d[3:0]]; // RULE19
        end
      end
      if (ser_cnt_q == ccp_pkg::SER_FRAME_BITS - 4'h1) begin
        ser_wr = ~ser_sh_d[12] & (ser_sh_d[11:8] < 4'(ccp_pkg::NUM_CR));
      end
    end
  end

  // Bus write wins over a serial write in the same cycle
  always_comb begin
    for (int i = 0; i < ccp_pkg::NUM_CR; i++) begin
      cr_d[i] = cr_q[i];
    end
    if (apb_wr) begin
      cr_d[apb_idx] = pwdata_i[7:0];
    end else if (ser_wr) begin
      cr_d[ser_sh_d[11:8]] = ser_sh_d[7:0]; // RULE19
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ccp_pkg::NUM_CR; i++) begin
        cr_q[i] <= (i == ccp_pkg::IDX_CR10) ? ccp_pkg::CR10_RST :
                   ccp_pkg::CR_RST;
      end
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      ser_cnt_q <= 4'h0;
      ser_sh_q <= 13'h0000;
      ser_out_q <= 8'h00;
    end else begin
      cr_q <= cr_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      ser_cnt_q <= ser_cnt_d;
      ser_sh_q <= ser_sh_d;
      ser_out_q <= ser_out_d;
    end
  end

  // ---------------------------------------------------------------
  // Effective controls: pin ORed with register bit
  // ---------------------------------------------------------------
  logic line_thr, aco_thr, line_att_off, aco_att_hi, pad_on, coef_req;
  logic pdn_req;
  logic [1:0] nc_code, ncpad_code;
  logic [15:0] init_cnt_q, init_cnt_d, coef_cnt_q, coef_cnt_d;
  logic [7:0] cr10;

  assign cr10 = cr_q[ccp_pkg::IDX_CR10];
  assign line_thr = samp_q.line_ec_through |
                    cr_q[ccp_pkg::IDX_CR4][ccp_pkg::CRX_THR_B];
  assign aco_thr = samp_q.acoustic_ec_through |
                   cr_q[ccp_pkg::IDX_CR5][ccp_pkg::CRX_THR_B];
  assign line_att_off = samp_q.line_howl_atten_en_n |
                        cr_q[ccp_pkg::IDX_CR4][ccp_pkg::CRX_ATT_B]; // RULE1
  assign aco_att_hi = samp_q.acoustic_atten_level_sel |
                      cr_q[ccp_pkg::IDX_CR5][ccp_pkg::CRX_ATT_B]; // RULE6
  assign pad_on = samp_q.pad_stage_mode |
                  cr_q[ccp_pkg::IDX_CR1][ccp_pkg::CR1_PAD_B]; // RULE10
  assign coef_req = ~samp_q.coef_reset_n |
                    cr_q[ccp_pkg::IDX_CR0][ccp_pkg::CR0_COEF_B]; // RULE14
  assign pdn_req = ~pins_s.powerdown_reset_n |
                   cr_q[ccp_pkg::IDX_CR0][ccp_pkg::CR0_PDN_B]; // RULE16
  assign nc_code = {pins_s.noise_sel_hi |
                    cr_q[ccp_pkg::IDX_CR12][ccp_pkg::CR12_NCHI_B],
                    pins_s.noise_sel_lo |
                    cr_q[ccp_pkg::IDX_CR1][ccp_pkg::CR1_NCLO_B]}; // RULE17
  assign ncpad_code = {pins_s.noise_pad_hi |
                       cr_q[ccp_pkg::IDX_CR5][ccp_pkg::CRX_NCPAD_B],
                       pins_s.noise_pad_lo |
                       cr_q[ccp_pkg::IDX_CR4][ccp_pkg::CRX_NCPAD_B]};

  // Powerdown, initial mode, and noise level latch at release
  always_comb begin
    mode_d = mode_q;
    init_cnt_d = init_cnt_q;
    nc_att_d = nc_att_q;
    case (mode_q)
      ccp_pkg::CCP_PDN: begin
        init_cnt_d = 16'h0000;
        if (!pdn_req) begin
          mode_d = ccp_pkg::CCP_INIT;
        end
      end
      ccp_pkg::CCP_INIT: begin
        init_cnt_d = init_cnt_q + 16'h0001;
        if (pdn_req) begin
          mode_d = ccp_pkg::CCP_PDN;
        end else if (init_cnt_q == 16'(INIT_CYCLES - 1)) begin
          mode_d = ccp_pkg::CCP_RUN;
          case (nc_code) // RULE15 RULE16
            2'b11: nc_att_d = ccp_pkg::NC_ATT_13P5;
            2'b10: nc_att_d = ccp_pkg::NC_ATT_8;
            default: nc_att_d = ccp_pkg::NC_ATT_17;
          endcase
        end
      end
      ccp_pkg::CCP_RUN: begin
        if (pdn_req) begin
          mode_d = ccp_pkg::CCP_PDN;
        end
      end
      default: mode_d = ccp_pkg::CCP_PDN;
    endcase
  end

  // Coefficient clear holds for a minimum time after the request
  always_comb begin
    coef_cnt_d = coef_cnt_q;
    if (coef_req) begin
      coef_cnt_d = 16'(COEF_CLR_CYCLES); // RULE14
    end else if (coef_cnt_q != 16'h0000) begin
      coef_cnt_d = coef_cnt_q - 16'h0001;
    end
  end

  // Attenuator steering, gain control, pads and noise controls
  always_comb begin
    ctrl_d = '0;
    if (!line_thr && !line_att_off) begin // RULE4
      ctrl_d.line_send_atten = line_recv_input_i &
                               ~line_send_input_i; // RULE2
      ctrl_d.line_recv_atten = line_send_input_i; // RULE2
    end
    if (ctrl_d.line_send_atten || ctrl_d.line_recv_atten) begin
      ctrl_d.line_atten_db = ccp_pkg::LINE_ATT_DB; // RULE3
    end
    if (!aco_thr) begin
      ctrl_d.acoustic_send_atten = acoustic_recv_input_i &
                                   ~acoustic_send_input_i; // RULE7
      ctrl_d.acoustic_recv_atten = acoustic_send_input_i; // RULE7
      ctrl_d.acoustic_atten_db = aco_att_hi ? ccp_pkg::ACO_ATT_HI_DB :
                                 ccp_pkg::ACO_ATT_LO_DB; // RULE6
    end
    ctrl_d.line_gain_ctrl_act = ~line_thr & line_rx_level_high_i &
      ~(samp_q.line_rx_gain_ctrl_dis |
        cr_q[ccp_pkg::IDX_CR4][ccp_pkg::CRX_GC_B]); // RULE8 RULE9
    ctrl_d.acoustic_gain_ctrl_act = ~aco_thr & acoustic_rx_level_high_i &
      ~(samp_q.acoustic_rx_gain_ctrl_dis |
        cr_q[ccp_pkg::IDX_CR5][ccp_pkg::CRX_GC_B]); // RULE8 RULE9
    ctrl_d.pad_active = pad_on;
    if (pad_on) begin
      ctrl_d.input_atten_pad = ccp_pkg::pad_db(
        cr10[ccp_pkg::CR10_IN_MAG_B +: 2],
        cr10[ccp_pkg::CR10_IN_NEG_B]); // RULE11
      ctrl_d.output_gain_pad = ccp_pkg::pad_db(
        cr10[ccp_pkg::CR10_OUT_MAG_B +: 2],
        cr10[ccp_pkg::CR10_OUT_NEG_B]); // RULE11
    end
    ctrl_d.coef_reset = coef_req | (coef_cnt_q != 16'h0000);
    ctrl_d.silence = ctrl_d.coef_reset | (mode_q != ccp_pkg::CCP_RUN);
    ctrl_d.noise_through = (nc_code == ccp_pkg::NC_THROUGH); // RULE15
    ctrl_d.noise_atten_x2 = nc_att_q;
    ctrl_d.noise_out_gain = ccp_pkg::pad_db(ncpad_code, 1'b0); // RULE18
    ctrl_d.noise_in_atten = ccp_pkg::pad_db(ncpad_code, 1'b1); // RULE18
    ctrl_d.ser_port_used = ser_used;
    ctrl_d.rx_gain_code = samp_q.rx_gain |
                          cr_q[ccp_pkg::IDX_CR2][3:0]; // RULE22
    ctrl_d.init_mode = (mode_q != ccp_pkg::CCP_RUN);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= ccp_pkg::CCP_PDN;
      init_cnt_q <= 16'h0000;
      nc_att_q <= ccp_pkg::NC_ATT_17;
      coef_cnt_q <= 16'h0000;
      ctrl_q <= '0;
    end else begin
      mode_q <= mode_d;
      init_cnt_q <= init_cnt_d;
      nc_att_q <= nc_att_d;
      coef_cnt_q <= coef_cnt_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign ser_data_out_o = ser_out_q[7];
  assign ctrl_o = ctrl_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_line_att_off;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    line_att_off |=> !ctrl_q.line_send_atten && !ctrl_q.line_recv_atten;
  endproperty
  a_line_att_off: assert property (p_line_att_off) // RULE1
    else $error("line attenuator active while disabled");

  property p_line_steer;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (!line_thr && !line_att_off && line_recv_input_i && !line_send_input_i)
      |=> ctrl_q.line_send_atten && !ctrl_q.line_recv_atten;
  endproperty
  a_line_steer: assert property (p_line_steer) // RULE2
    else $error("receive-only input did not pick send attenuator");

  property p_line_db;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ctrl_q.line_send_atten || ctrl_q.line_recv_atten)
      |-> ctrl_q.line_atten_db == 5'h06;
  endproperty
  a_line_db: assert property (p_line_db) // RULE3
    else $error("line attenuation not 6 dB");

  property p_line_thr;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    line_thr |=> !ctrl_q.line_send_atten && !ctrl_q.line_recv_atten;
  endproperty
  a_line_thr: assert property (p_line_thr) // RULE4
    else $error("line attenuator active in through mode");

  property p_frame_sample;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !$stable(samp_q) |-> $past(fs_rise);
  endproperty
  a_frame_sample: assert property (p_frame_sample) // RULE5
    else $error("pins sampled away from frame sync rise");

  property p_aco_level;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (!aco_thr && aco_att_hi) |=> ctrl_q.acoustic_atten_db == 5'h0C;
  endproperty
  a_aco_level: assert property (p_aco_level) // RULE6
    else $error("acoustic high level not 12 dB");

  property p_aco_steer;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (!aco_thr && acoustic_send_input_i) |=> ctrl_q.acoustic_recv_atten;
  endproperty
  a_aco_steer: assert property (p_aco_steer) // RULE7
    else $error("send input did not pick receive attenuator");

  property p_gain_level;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ctrl_q.line_gain_ctrl_act |-> $past(line_rx_level_high_i) &&
                                  !$past(line_thr);
  endproperty
  a_gain_level: assert property (p_gain_level) // RULE8 RULE9
    else $error("gain control acted below threshold or in through");

  property p_coef_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(coef_req) |-> (ctrl_q.coef_reset && ctrl_q.silence) [*3];
  endproperty
  a_coef_hold: assert property (p_coef_hold) // RULE14
    else $error("coefficient clear ended too early");

  property p_nc_latch;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_q == ccp_pkg::CCP_RUN && $past(mode_q) == ccp_pkg::CCP_RUN)
      |-> $stable(nc_att_q);
  endproperty
  a_nc_latch: assert property (p_nc_latch) // RULE16
    else $error("noise level changed during normal run");

  property p_nc_17;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_q == ccp_pkg::CCP_INIT && mode_d == ccp_pkg::CCP_RUN &&
     nc_code == 2'b00) |=> nc_att_q == 6'h22;
  endproperty
  a_nc_17: assert property (p_nc_17) // RULE15
    else $error("noise code 00 did not latch 17 dB");

  property p_rx_gain;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ##1 ctrl_q.rx_gain_code == ($past(samp_q.rx_gain) |
                                $past(cr_q[ccp_pkg::IDX_CR2][3:0]));
  endproperty
  a_rx_gain: assert property (p_rx_gain) // RULE22
    else $error("receive gain code not the OR of pin and register");

endmodule

// *** ccp_host.sv ***
// Host model: control pins, frame sync and idle serial port
`timescale 1ns/100ps
module ccp_host (
  input wire logic clk_sys_i,
  input wire ccp_pkg::ccp_pins_s want_i,
  output ccp_pkg::ccp_pins_s pins_o,
  output logic sync_o,
  output logic ser_en_n_o,
  output logic ser_clk_o,
  output logic ser_dat_o
);
  logic [5:0] cnt_q = 6'h00;
  // Frame sync every 64 clocks; pins move just after a rise, then hold
  always @(posedge clk_sys_i) begin
    cnt_q <= cnt_q + 6'h01;
    sync_o <= cnt_q[5];
    if (cnt_q == 6'h21) pins_o <= want_i;
  end
  // Start values before the first edge
  initial begin
    pins_o = ccp_pkg::PINS_RST;
    sync_o = 1'b0;
  end
  // Unused serial port rests at its idle levels
  assign ser_en_n_o = 1'b1;
  assign ser_clk_o = 1'b0;
  assign ser_dat_o = 1'b0;
endmodule

// *** canceler_control_pins_bench.sv ***
// Self-checking bench for the canceler control-pin block
`timescale 1ns/100ps
module canceler_control_pins_bench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] sig = 4'h0;
  logic lvl = 1'b1, err, fs, en_n, sck, sdi;
  ccp_pkg::ccp_pins_s want, pins;
  ccp_pkg::ccp_ctrl_s ctrl;
  int fails = 0, num_checks = 0, cyc = 0;
  logic [7:0] nc [4] = '{8'h22, 8'h62, 8'h10, 8'h1B};

  // ---------------------------------------------------------------
  // Clock, timeout and instances
  // ---------------------------------------------------------------
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  ccp_host u_host (.clk_sys_i(clk_sys_i), .want_i(want), .pins_o(pins),
    .sync_o(fs), .ser_en_n_o(en_n), .ser_clk_o(sck), .ser_dat_o(sdi));
  ccp_top #(.INIT_CYCLES(4), .COEF_CLR_CYCLES(4)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pins_i(pins), .frame_sync_i(fs),
    .ser_enable_n_i(en_n), .ser_shift_clk_i(sck), .ser_data_in_i(sdi),
    .ser_data_out_o(), .line_recv_input_i(sig[0]),
    .line_send_input_i(sig[1]), .acoustic_recv_input_i(sig[2]),
    .acoustic_send_input_i(sig[3]), .line_rx_level_high_i(lvl),
    .acoustic_rx_level_high_i(lvl), .ctrl_o(ctrl));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // One APB transfer; held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Two frame periods so pins and registers are captured
  task automatic settle();
    repeat (140) @(posedge clk_sys_i);
  endtask
  task automatic give_verdict();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, 8'h28, 8'h00);
    chk(rd, 32'h26);
    apb(1'b0, 8'h38, 8'h00);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 8'h08, 8'h05);
    settle();
    chk(ctrl.rx_gain_code, 4'h5);
    chk(ctrl.ser_port_used, 1'b0);
    want.ser_port_unused <= 1'b0;
    settle();
    chk(ctrl.ser_port_used, 1'b1);
    want.ser_port_unused <= 1'b1;
  endtask
  task automatic t_line();
    want.line_howl_atten_en_n <= 1'b0;
    sig <= 4'h1;
    settle();
    chk({ctrl.line_send_atten, ctrl.line_recv_atten}, 2'b10);
    chk(ctrl.line_atten_db, 5'h06);
    sig <= 4'h3;
    settle();
    chk({ctrl.line_send_atten, ctrl.line_recv_atten}, 2'b01);
    apb(1'b1, 8'h10, 8'h02);
    settle();
    chk({ctrl.line_send_atten, ctrl.line_recv_atten}, 2'b00);
    apb(1'b1, 8'h10, 8'h00);
    want.line_ec_through <= 1'b1;
    settle();
    chk({ctrl.line_send_atten, ctrl.line_recv_atten}, 2'b00);
  endtask
  task automatic t_aco();
    sig <= 4'h4;
    want.acoustic_atten_level_sel <= 1'b1;
    settle();
    chk({ctrl.acoustic_send_atten, ctrl.acoustic_atten_db}, 6'h2C);
    apb(1'b1, 8'h14, 8'h02);
    want.acoustic_atten_level_sel <= 1'b0;
    settle();
    chk(ctrl.acoustic_atten_db, 5'h0C);
    apb(1'b1, 8'h14, 8'h00);
    settle();
    chk(ctrl.acoustic_atten_db, 5'h06);
    chk(ctrl.acoustic_gain_ctrl_act, 1'b1);
    lvl <= 1'b0;
    settle();
    chk(ctrl.acoustic_gain_ctrl_act, 1'b0);
    lvl <= 1'b1;
  endtask
  task automatic t_pad();
    apb(1'b1, 8'h04, 8'h04);
    settle();
    chk({ctrl.pad_active, ctrl.input_atten_pad, ctrl.output_gain_pad},
        13'h1D0C);
    apb(1'b1, 8'h00, 8'h40);
    settle();
    chk({ctrl.coef_reset, ctrl.silence}, 2'b11);
    apb(1'b1, 8'h00, 8'h00);
    settle();
    chk({ctrl.coef_reset, ctrl.silence}, 2'b00);
    apb(1'b1, 8'h10, 8'h04);
    settle();
    chk({ctrl.noise_out_gain, ctrl.noise_in_atten}, 12'h1BA);
  endtask
  task automatic t_noise();
    for (int c = 0; c < 4; c++) begin
      {want.noise_sel_hi, want.noise_sel_lo} <= 2'(c);
      settle();
      apb(1'b1, 8'h00, 8'h80);
      apb(1'b1, 8'h00, 8'h00);
      settle();
      chk({ctrl.noise_through, ctrl.noise_atten_x2}, nc[c]);
    end
    {want.noise_sel_hi, want.noise_sel_lo} <= 2'b01;
    settle();
    chk({ctrl.noise_through, ctrl.noise_atten_x2}, 8'h5B);
    apb(1'b1, 8'h30, 8'h04);
    settle();
    chk({ctrl.noise_through, ctrl.noise_atten_x2}, 8'h1B);
    apb(1'b0, 8'h34, 8'h00);
    chk(rd, 32'h6F);
  endtask

  initial begin
    want = '0;
    want.coef_reset_n = 1'b1;
    want.powerdown_reset_n = 1'b1;
    want.ser_port_unused = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_line();
    t_aco();
    t_pad();
    t_noise();
    give_verdict();
  end
endmodule
